// ### mtf_pkg.sv
// Purpose: Constants for the MAC transmit, flow and management config words
// Assumes: Host interface selects config space with address bit 9 set
// Notes:   Reserved bits are masked out on write and read back as zero
package mtf_pkg;
    // Host address decode
    localparam int          ADDR_W       = 10;
    localparam int          CFG_SEL_BIT  = 9;
    localparam int          IDX_HI       = 8;
    localparam int          IDX_LO       = 6;
    localparam logic [2:0]  IDX_TX       = 3'h2;
    localparam logic [2:0]  IDX_FC       = 3'h3;
    localparam logic [2:0]  IDX_MG       = 3'h5;
    localparam int          OP_RD_BIT    = 1;
    // Transmitter word bit positions
    localparam int          TXB_IFG      = 25;
    localparam int          TXB_VLAN     = 27;
    localparam int          TXB_EN       = 28;
    localparam int          TXB_INBAND   = 29;
    localparam int          TXB_JUMBO    = 30;
    localparam int          TXB_RST      = 31;
    // Flow control word bit positions
    localparam int          FCB_RX       = 29;
    localparam int          FCB_TX       = 30;
    // Management word fields
    localparam int          MGB_DIV_HI   = 4;
    localparam int          MGB_DIV_LO   = 0;
    localparam int          MGB_MDIO_EN  = 5;
    // Storable bits and reset values
    localparam logic [31:0] TX_MASK      = 32'h7A00_0000;
    localparam logic [31:0] TX_RESET     = 32'h1000_0000;
    localparam logic [31:0] FC_MASK      = 32'h6000_0000;
    localparam logic [31:0] FC_RESET     = 32'h6000_0000;
    localparam logic [31:0] MG_MASK      = 32'h0000_003F;
    localparam logic [31:0] MG_RESET     = 32'h0000_0000;
    localparam logic [31:0] RD_ANY_MASK  = TX_MASK | FC_MASK | MG_MASK;
    localparam logic [31:0] RD_NONE      = 32'h0000_0000;
endpackage : mtf_pkg

// ### mtf_cfg.sv
// Purpose: Transmitter, flow control and management config word bank
// Assumes: All inputs synchronous to clk_in; one access per cycle
// Notes:   Only the tx word waits for a gap; flow and mgmt act at once
// Operation
// - Gap adjust samples delay at frame start
// - VLAN enable bit, resets to zero
// - Transmit enable defaults one, zero disables
// - In-band FCS: client supplies FCS
// - FCS clear: pad, compute, append FCS
// - Jumbo bit allows over-length frames
// - Reset bit resets transmitter, self-clears
// - Transmitter reset restores config defaults
// - RX flow enable: pause inhibits transmitter
// - RX flow off: pause forwarded, ignored
// - TX flow enable: request sends pause
// - TX flow off: pause request ignored
// - Five-bit management clock divide, resets zero
// - Management enable allows MDIO access
// - Management disabled holds MDIO inactive
// - Transmit config applied only between frames
// - Reset bit acts immediately
// - Read data valid edge after address
`timescale 1ns/10ps
`default_nettype none
module mtf_cfg #(
    parameter int IFG_W = 8                      // Gap delay port width
) (
    input  wire logic                        clk_in,            // 125 MHz
    input  wire logic                        rst_n_in,          // Sync reset
    input  wire logic                        ce_in,             // Clock enable
    input  wire logic [1:0]                  host_opcode_in,    // Op code
    input  wire logic [mtf_pkg::ADDR_W-1:0]  host_addr_in,      // Address
    input  wire logic [31:0]                 host_wr_data_in,   // Write data
    input  wire logic                        host_miim_sel_in,  // MDIO select
    output var  logic [31:0]                 host_rd_data_out,  // Read data
    input  wire logic                        tx_frame_active_in,// In frame
    input  wire logic                        tx_frame_start_in, // Frame start
    input  wire logic [IFG_W-1:0]            tx_ifg_delay_in,   // Extra gap
    input  wire logic                        pause_req_in,      // Pause request
    input  wire logic                        rx_pause_in,       // Pause received
    output var  logic                        tx_ifg_adj_en_out, // Gap adjust on
    output var  logic [IFG_W-1:0]            tx_ifg_delay_out,  // Latched gap
    output var  logic                        tx_vlan_en_out,    // VLAN allowed
    output var  logic                        tx_en_out,         // Tx running
    output var  logic                        tx_fcs_gen_out,    // Make FCS
    output var  logic                        tx_jumbo_en_out,   // Jumbo allowed
    output var  logic                        tx_reset_out,      // Tx reset
    output var  logic                        pause_send_out,    // Send pause
    output var  logic                        tx_inhibit_out,    // Hold tx
    output var  logic                        rx_pause_fwd_out,  // Pass pause up
    output var  logic [4:0]                  mdc_div_out,       // MDC divide
    output var  logic                        mdio_en_out        // MDIO enable
);
    import mtf_pkg::*;

    typedef struct packed {
        logic [31:0]      tx_word;
        logic [31:0]      act_tx;
        logic [31:0]      fc_word;
        logic [31:0]      mg_word;
        logic [31:0]      rd_data;
        logic [IFG_W-1:0] ifg;
        logic             tx_rst;
        logic             pause_send;
        logic             inhibit;
        logic             pause_fwd;
        logic             fcs_gen;
    } mtf_state_t;

    mtf_state_t q;
    mtf_state_t next_q;

    // Access decode
    logic       cfg_sel;
    logic       wr_en;
    logic       rd_en;
    logic [2:0] idx;
    logic       wr_tx;
    logic       tx_rst_req;

    assign cfg_sel = host_addr_in[CFG_SEL_BIT] && !host_miim_sel_in;
    assign idx     = host_addr_in[IDX_HI:IDX_LO];
    assign wr_en   = cfg_sel && !host_opcode_in[OP_RD_BIT];
    assign rd_en   = cfg_sel && host_opcode_in[OP_RD_BIT];
    assign wr_tx   = wr_en && (idx == IDX_TX);
    assign tx_rst_req = wr_tx && host_wr_data_in[TXB_RST];

    // Next state of the whole bank
    always_comb begin
        next_q = q;
        next_q.tx_rst = 1'b0;
        if (wr_tx) begin
            next_q.tx_word = host_wr_data_in & TX_MASK;
        end
        if (wr_en && (idx == IDX_FC)) begin
            next_q.fc_word = host_wr_data_in & FC_MASK;
        end
        if (wr_en && (idx == IDX_MG)) begin
            next_q.mg_word = host_wr_data_in & MG_MASK;
        end
        // hold config while a frame is in flight
        if (!tx_frame_active_in) begin
            next_q.act_tx = q.tx_word;
        end
        // latch gap delay once per frame
        if (tx_frame_start_in && q.act_tx[TXB_IFG]) begin
            next_q.ifg = tx_ifg_delay_in;
        end
        // reset wins at once, mid-frame too
        if (tx_rst_req) begin
            next_q.tx_rst  = 1'b1;
            next_q.tx_word = TX_RESET;
            next_q.act_tx  = TX_RESET;
            next_q.ifg     = '0;
        end
        // FCS generate flag in its own flop, no inverter at the pin
        next_q.fcs_gen = !next_q.act_tx[TXB_INBAND];
        // pause request gated by tx flow enable
        next_q.pause_send = pause_req_in && q.fc_word[FCB_TX];
        next_q.inhibit    = rx_pause_in && q.fc_word[FCB_RX];
        next_q.pause_fwd  = rx_pause_in && !q.fc_word[FCB_RX];
        // read mux, unmapped words read zero
        if (rd_en) begin
            case (idx)
                IDX_TX:  next_q.rd_data = q.tx_word;
                IDX_FC:  next_q.rd_data = q.fc_word;
                IDX_MG:  next_q.rd_data = q.mg_word;
                default: next_q.rd_data = RD_NONE;
            endcase
        end else begin
            next_q.rd_data = RD_NONE;
        end
    end

    // State register; reset wins over a frozen clock enable
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q.tx_word    <= TX_RESET;
            q.act_tx     <= TX_RESET;
            q.fc_word    <= FC_RESET;
            q.mg_word    <= MG_RESET;
            q.rd_data    <= RD_NONE;
            q.ifg        <= '0;
            q.tx_rst     <= 1'b0;
            q.pause_send <= 1'b0;
            q.inhibit    <= 1'b0;
            q.pause_fwd  <= 1'b0;
            q.fcs_gen    <= !TX_RESET[TXB_INBAND];
        end else if (ce_in) begin
            q <= next_q;
        end
    end

    // Outputs straight from the state flops
    assign host_rd_data_out  = q.rd_data;
    assign tx_ifg_adj_en_out = q.act_tx[TXB_IFG];
    assign tx_ifg_delay_out  = q.ifg;
    assign tx_vlan_en_out    = q.act_tx[TXB_VLAN];
    assign tx_en_out         = q.act_tx[TXB_EN];
    // FCS made only when client does not supply it
    assign tx_fcs_gen_out    = q.fcs_gen;
    assign tx_jumbo_en_out   = q.act_tx[TXB_JUMBO];
    assign tx_reset_out      = q.tx_rst;
    assign pause_send_out    = q.pause_send;
    assign tx_inhibit_out    = q.inhibit;
    assign rx_pause_fwd_out  = q.pause_fwd;
    assign mdc_div_out       = q.mg_word[MGB_DIV_HI:MGB_DIV_LO];
    // MDIO gate; engine idles its pins while low
    assign mdio_en_out       = q.mg_word[MGB_MDIO_EN];

    // Checks on the bank
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_tx_rst_pulse;
        ce_in && tx_rst_req |=> tx_reset_out
            ##1 (!tx_reset_out || !$past(ce_in) || $past(tx_rst_req));
    endproperty
    a_tx_rst_pulse: assert property (p_tx_rst_pulse)
        else $error("tx reset not a self-clearing pulse");

    property p_tx_rst_defaults;
        ce_in && tx_rst_req |=> (q.tx_word == TX_RESET) && tx_en_out
            && !tx_vlan_en_out && tx_fcs_gen_out && !tx_jumbo_en_out;
    endproperty
    a_tx_rst_defaults: assert property (p_tx_rst_defaults)
        else $error("tx reset did not restore defaults");

    property p_mid_frame_hold;
        tx_frame_active_in && !tx_rst_req |=> $stable(q.act_tx);
    endproperty
    a_mid_frame_hold: assert property (p_mid_frame_hold)
        else $error("tx config changed mid frame");

    property p_pause_send;
        ce_in && pause_req_in && q.fc_word[FCB_TX] |=> pause_send_out;
    endproperty
    a_pause_send: assert property (p_pause_send)
        else $error("pause request not forwarded");

    property p_pause_ignore;
        ce_in && !q.fc_word[FCB_TX] |=> !pause_send_out;
    endproperty
    a_pause_ignore: assert property (p_pause_ignore)
        else $error("pause sent while tx flow disabled");

    property p_rx_pause_fwd;
        ce_in && rx_pause_in && !q.fc_word[FCB_RX]
            |=> rx_pause_fwd_out && !tx_inhibit_out;
    endproperty
    a_rx_pause_fwd: assert property (p_rx_pause_fwd)
        else $error("pause not forwarded with rx flow off");

    property p_rx_pause_inhibit;
        ce_in && rx_pause_in && q.fc_word[FCB_RX]
            |=> tx_inhibit_out && !rx_pause_fwd_out;
    endproperty
    a_rx_pause_inhibit: assert property (p_rx_pause_inhibit)
        else $error("pause did not inhibit transmitter");

    property p_rd_mgmt;
        ce_in && rd_en && (idx == IDX_MG)
            |=> host_rd_data_out == $past(q.mg_word);
    endproperty
    a_rd_mgmt: assert property (p_rd_mgmt)
        else $error("management word read wrong or late");

    property p_reserved_zero;
        (host_rd_data_out & ~RD_ANY_MASK) == RD_NONE;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved read bit set");

    property p_ifg_latch;
        ce_in && tx_frame_start_in && tx_ifg_adj_en_out && !tx_rst_req
            |=> tx_ifg_delay_out == $past(tx_ifg_delay_in);
    endproperty
    a_ifg_latch: assert property (p_ifg_latch)
        else $error("gap delay not latched at frame start");

    property p_mdio_off;
        ce_in && wr_en && (idx == IDX_MG) && !host_wr_data_in[MGB_MDIO_EN]
            |=> !mdio_en_out;
    endproperty
    a_mdio_off: assert property (p_mdio_off)
        else $error("MDIO stayed enabled");

    property p_tx_en_apply;
        ce_in && !tx_frame_active_in && !tx_rst_req
            |=> tx_en_out == $past(q.tx_word[TXB_EN]);
    endproperty
    a_tx_en_apply: assert property (p_tx_en_apply)
        else $error("tx enable not applied in gap");

    property p_vlan_apply;
        ce_in && !tx_frame_active_in && !tx_rst_req
            |=> tx_vlan_en_out == $past(q.tx_word[TXB_VLAN]);
    endproperty
    a_vlan_apply: assert property (p_vlan_apply)
        else $error("VLAN enable not applied in gap");

    property p_jumbo_apply;
        ce_in && !tx_frame_active_in && !tx_rst_req
            |=> tx_jumbo_en_out == $past(q.tx_word[TXB_JUMBO]);
    endproperty
    a_jumbo_apply: assert property (p_jumbo_apply)
        else $error("jumbo enable not applied in gap");

    property p_fcs_client;
        q.act_tx[TXB_INBAND] |-> !tx_fcs_gen_out;
    endproperty
    a_fcs_client: assert property (p_fcs_client)
        else $error("FCS generated though client supplies it");

    property p_fcs_gen;
        !q.act_tx[TXB_INBAND] |-> tx_fcs_gen_out;
    endproperty
    a_fcs_gen: assert property (p_fcs_gen)
        else $error("FCS not generated with in-band FCS off");

    property p_mdc_div;
        ce_in && wr_en && (idx == IDX_MG)
            |=> mdc_div_out == $past(host_wr_data_in[MGB_DIV_HI:MGB_DIV_LO]);
    endproperty
    a_mdc_div: assert property (p_mdc_div)
        else $error("clock divide not stored");

    property p_mdio_on;
        ce_in && wr_en && (idx == IDX_MG) && host_wr_data_in[MGB_MDIO_EN]
            |=> mdio_en_out;
    endproperty
    a_mdio_on: assert property (p_mdio_on)
        else $error("MDIO not enabled");

    property p_rst_mid_frame;
        ce_in && tx_rst_req && tx_frame_active_in
            |=> tx_reset_out && tx_en_out && !(|tx_ifg_delay_out);
    endproperty
    a_rst_mid_frame: assert property (p_rst_mid_frame)
        else $error("tx reset waited for a gap");

    property p_rd_tx;
        ce_in && rd_en && (idx == IDX_TX)
            |=> host_rd_data_out == $past(q.tx_word);
    endproperty
    a_rd_tx: assert property (p_rd_tx)
        else $error("tx word read wrong or late");

    property p_rd_fc;
        ce_in && rd_en && (idx == IDX_FC)
            |=> host_rd_data_out == $past(q.fc_word);
    endproperty
    a_rd_fc: assert property (p_rd_fc)
        else $error("flow word read wrong or late");

    property p_rd_idle;
        ce_in && !rd_en |=> host_rd_data_out == RD_NONE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle without a read");

    property p_fc_masked;
        ce_in && wr_en && (idx == IDX_FC)
            |=> q.fc_word == ($past(host_wr_data_in) & FC_MASK);
    endproperty
    a_fc_masked: assert property (p_fc_masked)
        else $error("flow word stored reserved bits");

    property p_ifg_hold;
        ce_in && !tx_frame_start_in && !tx_rst_req
            |=> $stable(tx_ifg_delay_out);
    endproperty
    a_ifg_hold: assert property (p_ifg_hold)
        else $error("gap delay moved between frame starts");

    c_tx_reset:   cover property (ce_in && tx_rst_req ##1 tx_reset_out);
    c_pause_send: cover property (pause_send_out);
    c_rd_tx:      cover property (ce_in && rd_en && (idx == IDX_TX));
    c_mid_write:  cover property (tx_frame_active_in && wr_tx);
    c_rx_inhibit: cover property (tx_inhibit_out);

endmodule : mtf_cfg
`default_nettype wire

// ### mtf_host.sv
// Purpose: Host processor model driving the config word access bus
// Assumes: Bus lines change only on falling clock edges
// Notes:   Released write data shows its inverse, never the last value
`timescale 1ns/10ps
`default_nettype none
module mtf_host (
    input  wire logic                       clk_in,            // Host clock
    output var  logic [1:0]                 host_opcode_out,   // Op code
    output var  logic [mtf_pkg::ADDR_W-1:0] host_addr_out,     // Address
    output var  logic [31:0]                host_wr_data_out,  // Write data
    output var  logic                       host_miim_sel_out, // MDIO select
    input  wire logic [31:0]                host_rd_data_in    // Read data
);
    import mtf_pkg::*;

    // Idle bus: config space not selected
    initial begin
        host_opcode_out   = 2'h3;
        host_addr_out     = '0;
        host_wr_data_out  = 32'h0000_0000;
        host_miim_sel_out = 1'b0;
    end

    // One access: held across one rising edge, answer taken at the next fall
    task automatic access(input logic rd, input logic [ADDR_W-1:0] a,
                          input logic [31:0] d, input logic ms,
                          output logic [31:0] q);
        @(negedge clk_in);
        host_opcode_out   = {rd, 1'b1};  // Low bit set to show it is ignored
        host_addr_out     = a;
        host_wr_data_out  = d;
        host_miim_sel_out = ms;
        @(negedge clk_in);
        q                 = host_rd_data_in;
        host_addr_out     = '0;
        host_wr_data_out  = ~d;
        host_miim_sel_out = 1'b0;
    endtask
endmodule // mtf_host
`default_nettype wire

// ### test_mtf_cfg.sv
// Purpose: Self-checking bench for the config word bank
// Assumes: Host model accesses; frame and pause inputs set at falling edge
// Notes:   Output groups are packed into vectors for one compare each
`timescale 1ns/10ps
`default_nettype none
module test_mtf_cfg;
    import mtf_pkg::*;
    logic        clk_in = 0, rst_n_in = 0, fa = 0, fs = 0, preq = 0, rxp = 0;
    logic [7:0]  dly = 8'h00;
    logic        ce = 1;
    logic [1:0]  op;
    logic [9:0]  addr;
    logic [31:0] wd, rdd, q;
    logic        msel, ifg, vlan, en, fcs, jmb, trst, psend, inh, fwd, mdio;
    logic [7:0]  ifg_dly;
    logic [4:0]  div;
    int          miscompares = 0, checks_done = 0;
    wire  [31:0] tx_vec = {26'h0, ifg, vlan, en, fcs, jmb, trst};
    wire  [31:0] fl_vec = {29'h0, psend, inh, fwd};
    wire  [31:0] mg_vec = {26'h0, mdio, div};

    always #4 clk_in = ~clk_in;

    mtf_host mtf_host_i (.clk_in(clk_in), .host_opcode_out(op),
        .host_addr_out(addr), .host_wr_data_out(wd),
        .host_miim_sel_out(msel), .host_rd_data_in(rdd));

    mtf_cfg mtf_cfg_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .host_opcode_in(op), .host_addr_in(addr), .host_wr_data_in(wd),
        .host_miim_sel_in(msel), .host_rd_data_out(rdd),
        .tx_frame_active_in(fa), .tx_frame_start_in(fs),
        .tx_ifg_delay_in(dly), .pause_req_in(preq), .rx_pause_in(rxp),
        .tx_ifg_adj_en_out(ifg), .tx_ifg_delay_out(ifg_dly),
        .tx_vlan_en_out(vlan), .tx_en_out(en), .tx_fcs_gen_out(fcs),
        .tx_jumbo_en_out(jmb), .tx_reset_out(trst), .pause_send_out(psend),
        .tx_inhibit_out(inh), .rx_pause_fwd_out(fwd), .mdc_div_out(div),
        .mdio_en_out(mdio));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        mtf_host_i.access(1'b1, a, 32'h0000_0000, 1'b0, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        mtf_host_i.access(1'b0, a, d, 1'b0, q);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog, far beyond the fewer than 80 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge clk_in);
        rst_n_in = 1;
        rd(10'h280, 32'h1000_0000);
        chk(tx_vec, 32'h0000_000C);
        rd(10'h2C0, 32'h6000_0000);
        rd(10'h340, 32'h0000_0000);
        $display("Test defaults done");
        wr(10'h37F, 32'hFFFF_FFFF);
        chk(mg_vec, 32'h0000_003F);
        rd(10'h340, 32'h0000_003F);
        wr(10'h340, 32'h0000_0015);
        chk(mg_vec, 32'h0000_0015);
        wr(10'h300, 32'hFFFF_FFFF);
        rd(10'h300, 32'h0000_0000);
        rd(10'h200, 32'h0000_0000);
        $display("Test management done");
        fa = 1;
        wr(10'h2BF, 32'h6FFF_FFFF);
        rd(10'h280, 32'h6A00_0000);
        chk(tx_vec, 32'h0000_000C);
        fa = 0;
        repeat (2) @(negedge clk_in);
        chk(tx_vec, 32'h0000_0032);
        fs  = 1;
        dly = 8'h5A;
        @(negedge clk_in);
        fs  = 0;
        dly = 8'hA5;
        chk({24'h0, ifg_dly}, 32'h0000_005A);
        $display("Test transmit config done");
        fa = 1;
        wr(10'h2A0, 32'h8000_0000);
        chk(tx_vec, 32'h0000_000D);
        chk({24'h0, ifg_dly}, 32'h0000_0000);
        @(negedge clk_in);
        chk(tx_vec, 32'h0000_000C);
        fa = 0;
        rd(10'h280, 32'h1000_0000);
        $display("Test transmitter reset done");
        for (int i = 0; i < 4; i++) begin
            wr(10'h2C0, {1'b1, i[1:0], 29'h1FFF_FFFF});
            preq = 1;
            rxp  = 1;
            @(negedge clk_in);
            chk(fl_vec, {29'h0, i[1], i[0], ~i[0]});
            preq = 0;
            rxp  = 0;
            rd(10'h2FF, {1'b0, i[1:0], 29'h0});
        end
        $display("Test flow control done");
        // Frozen enable and MDIO select leave no mark; a mid-run reset restores defaults
        ce = 0;
        wr(10'h340, 32'h0000_0021);
        chk(mg_vec, 32'h0000_0015);
        ce = 1;
        mtf_host_i.access(1'b0, 10'h340, 32'h0000_0021, 1'b1, q);
        rd(10'h340, 32'h0000_0015);
        wr(10'h280, 32'h4800_0000);
        rst_n_in = 0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1;
        rd(10'h340, 32'h0000_0000);
        rd(10'h280, 32'h1000_0000);
        $display("Test freeze, select and reset done");
        summarize();
    end
endmodule // test_mtf_cfg
`default_nettype wire
